/* hdl/acc_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants and types for the conversion control block
// ----------------------------------------------------------------------------
package acc_pkg;

  // ----------------------------------------------------------------------------
  // widths and clock
  // ----------------------------------------------------------------------------
  localparam int RESULT_W     = 24;          // converter word width
  localparam int TEMP_W       = 16;          // die temperature word width
  localparam int PERIOD_W     = 22;          // conversion period counter width
  localparam int SPS_W        = 20;          // reported output rate width
  localparam int CLK_HZ       = 10_000_000;  // system clock rate in hz

  // ----------------------------------------------------------------------------
  // temperature thresholds, 1 lsb = 1/64 degree c, two's complement
  // ----------------------------------------------------------------------------
  localparam int TEMP_LSB_PER_C = 64;
  localparam int TEMP_WARN_C    = 145;       // overtemperature warning
  localparam int TEMP_SHUT_C    = 165;       // automatic shutdown
  localparam logic [TEMP_W-1:0] TEMP_WARN_CODE = TEMP_W'(TEMP_WARN_C * TEMP_LSB_PER_C);
  localparam logic [TEMP_W-1:0] TEMP_SHUT_CODE = TEMP_W'(TEMP_SHUT_C * TEMP_LSB_PER_C);

  // ----------------------------------------------------------------------------
  // data rate limits and line rejection corner
  // ----------------------------------------------------------------------------
  localparam int NORMAL_MAX_SPS  = 576_000;
  localparam int NORMAL_MIN_SPS  = 15;
  localparam int SINGLE_MAX_SPS  = 144_000;
  localparam int SINGLE_MIN_SPS  = 3;
  localparam int LINE_REJECT_SPS = 60;       // at or below this, 50/60 hz notch

  // ----------------------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_IN1, SEL_IN2, SEL_IN3, SEL_IN4,
    SEL_COMMON, SEL_CAL_HIGH, SEL_CAL_LOW, SEL_GROUND
  } acc_hv_sel_t;

  typedef enum logic [2:0] {
    LV_AMP, LV_AUX_PAIR, LV_ANALOG_SUPPLY, LV_POS_HV_SUPPLY,
    LV_NEG_HV_SUPPLY, LV_COARSE_REF
  } acc_lv_sel_t;

  typedef enum logic [2:0] {
    RM_ONE_CH_ONE, RM_ONE_CH_CONT, RM_MULTI_ONE, RM_MULTI_MULTI, RM_MULTI_CONT
  } acc_read_mode_t;

  typedef enum logic [1:0] {
    CLK_INTERNAL, CLK_CRYSTAL, CLK_EXTERNAL
  } acc_clk_src_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_CONV, ST_STORE
  } acc_state_t;

  // rate code to output rate: normal spans 576k..15, single-cycle 144k..3
  function automatic int acc_rate_sps(input logic [2:0] code, input logic single);
    int n;
    case (code)
      3'h0:    n = NORMAL_MAX_SPS;
      3'h1:    n = 288_000;
      3'h2:    n = 144_000;
      3'h3:    n = 72_000;
      3'h4:    n = 16_000;
      3'h5:    n = 1_000;
      3'h6:    n = LINE_REJECT_SPS;
      default: n = NORMAL_MIN_SPS;
    endcase
    if (single)
      acc_rate_sps = (code == 3'h7) ? SINGLE_MIN_SPS : n / 4;
    else
      acc_rate_sps = n;
  endfunction : acc_rate_sps

endpackage : acc_pkg

/* hdl/acc_conv_ctrl.sv */
// Contract
// - positive selector offers four positive inputs
// - negative selector offers four negative inputs
// - both add common, cal high/low, ground
// - chop: two conversions, average of difference
// - chop halves effective output rate
// - invert sign for common/ground versus negative
// - die temperature kept as readable 16-bit value
// - warn 145, shutdown 165, user alarm
// - five read modes supported
// - burst command returns several channels together
// - normal settling rate 576 ksps to 15
// - single-cycle settling rate 144 ksps to 3
// - selectable sinc cascade and settling mode; the cascade only follows i_settle_single (4 stages single-cycle, 1 otherwise)
// - low rates reject 50 and 60 hz
// - sync pin, start request, frame end synchronise
// - low-voltage selector routes aux and diagnostics
// - clock source: oscillator, crystal or external
// - sequencer scans enabled channels unattended
// - ready output high when result available
// - interrupt output driven low on alarms
`timescale 1ns/1ps
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int NCH = 8                             // sequencer channel slots
)(
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // conversion control
  input  wire logic                  i_start,           // one-cycle start request
  input  wire logic                  i_stop,            // one-cycle abort
  input  wire logic [2:0]            i_read_mode,
  input  wire logic                  i_trig_on_sync,
  input  wire logic                  i_trig_on_frame_end,
  // channel configuration
  input  wire logic [NCH-1:0]        i_ch_enable,
  input  wire logic [3*NCH-1:0]      i_ch_pos_sel,
  input  wire logic [3*NCH-1:0]      i_ch_neg_sel,
  input  wire logic [NCH-1:0]        i_channel_chop_enable,
  // filter, low-voltage path and clock configuration
  input  wire logic                  i_settle_single,
  input  wire logic [2:0]            i_rate_code,
  input  wire logic [2:0]            i_lv_sel,
  input  wire logic [1:0]            i_clk_src,
  // modulator path
  input  wire logic [RESULT_W-1:0]   i_adc_sample,
  output logic [2:0]                 o_pos_sel,
  output logic [2:0]                 o_neg_sel,
  output logic [2:0]                 o_lv_sel,
  output logic                       o_converting,
  output logic                       o_filter_single_cycle,
  output logic [2:0]                 o_sinc_stages,
  output logic                       o_line_reject,
  output logic [SPS_W-1:0]           o_rate_sps,
  // results
  output logic [RESULT_W-1:0]        o_result,
  output logic [3:0]                 o_result_ch,
  output logic                       o_result_ready_out,
  input  wire logic                  i_result_ack,
  // burst readout
  input  wire logic                  i_burst_cmd,
  output logic                       o_burst_valid,
  input  wire logic                  i_burst_ready,
  output logic [RESULT_W-1:0]        o_burst_word,
  output logic [3:0]                 o_burst_ch,
  output logic                       o_burst_last,
  // host pins
  input  wire logic                  i_sync,
  input  wire logic                  i_sclk,
  input  wire logic                  i_chip_select_n,
  // temperature
  input  wire logic [TEMP_W-1:0]     i_temp_sample,
  input  wire logic                  i_temp_valid,
  input  wire logic [TEMP_W-1:0]     i_temp_alarm_thr,
  input  wire logic                  i_shutdown_clear,
  output logic [TEMP_W-1:0]          o_temp_reading,
  output logic                       o_temp_warning,
  output logic                       o_temp_alarm,
  output logic                       o_temp_shutdown,
  output logic                       o_interrupt_out_n,
  // clock source enables
  output logic                       o_osc_enable,
  output logic                       o_xtal_enable,
  output logic                       o_ext_clk_sel
);

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;
  if (NCH < 2 || NCH > 16) begin : g_bad_nch
    $error("NCH must lie between 2 and 16");
  end

  // ----------------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------------
  // next enabled slot after cur; msb flags a wrap to a lower or equal slot
  function automatic logic [CH_W:0] next_on(input logic [NCH-1:0] m,
                                            input logic [CH_W-1:0] cur);
    logic [CH_W:0] r;
    logic          hit;
    int            j;
    r   = {1'b1, cur};
    hit = 1'b0;
    for (int i = 1; i < NCH; i++)
    begin
      j = (int'(cur) + i) % NCH;
      if (!hit && m[j])
      begin
        hit = 1'b1;
        r   = {(j <= int'(cur)), CH_W'(j)};
      end
    end
    next_on = r;
  endfunction : next_on

  // lowest enabled slot
  function automatic logic [CH_W-1:0] first_on(input logic [NCH-1:0] m);
    logic [CH_W-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (m[i])
        r = CH_W'(i);
    end
    first_on = r;
  endfunction : first_on

  // ----------------------------------------------------------------------------
  // pin synchronisers, three stages, level accepted when stages two and three agree
  // ----------------------------------------------------------------------------
  logic [2:0] sync_s;                     // sync pin chain
  logic [2:0] sclk_s;                     // serial clock chain
  logic [2:0] cs_s;                       // chip select chain
  logic       sync_f;                     // filtered sync level
  logic       sclk_f;                     // filtered serial clock
  logic       cs_f;                       // filtered chip select
  logic       sclk_fell;                  // a falling clock edge seen in this frame

  // chains and filtered levels
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      sync_s    <= 3'h0;
      sclk_s    <= 3'h0;
      cs_s      <= 3'h7;
      sync_f    <= 1'b0;
      sclk_f    <= 1'b0;
      cs_f      <= 1'b1;
      sclk_fell <= 1'b0;
    end
    else
    begin
      sync_s <= {sync_s[1:0], i_sync};
      sclk_s <= {sclk_s[1:0], i_sclk};
      cs_s   <= {cs_s[1:0], i_chip_select_n};
      if (sync_s[1] == sync_s[2])
        sync_f <= sync_s[2];
      if (sclk_s[1] == sclk_s[2])
        sclk_f <= sclk_s[2];
      if (cs_s[1] == cs_s[2])
        cs_f <= cs_s[2];
      // remember the last falling clock edge while the frame is open
      if (cs_f)
        sclk_fell <= 1'b0;
      else if (sclk_f && sclk_s[1] == sclk_s[2] && !sclk_s[2])
        sclk_fell <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // conversion triggers
  // ----------------------------------------------------------------------------
  wire sync_rise   = !sync_f && sync_s[1] == sync_s[2] && sync_s[2];
  wire frame_close = !cs_f && cs_s[1] == cs_s[2] && cs_s[2];
  wire trigger     = i_start
                   | (i_trig_on_sync && sync_rise)
                   | (i_trig_on_frame_end && frame_close && sclk_fell);

  // ----------------------------------------------------------------------------
  // rate and filter selection
  // ----------------------------------------------------------------------------
  wire signed [31:0] sps    = acc_rate_sps(i_rate_code, i_settle_single);
  wire signed [31:0] period = (CLK_HZ / sps < 1) ? 32'sh1 : CLK_HZ / sps;
  // settling choice: single-cycle uses the deeper cascade
  wire [2:0] sinc_next = i_settle_single ? 3'h4 : 3'h1;

  // ----------------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------------
  acc_state_t           state;            // conversion state
  acc_read_mode_t       mode;             // mode latched at start
  logic [CH_W-1:0]      cur_ch;           // slot being converted
  logic [PERIOD_W-1:0]  cnt;              // cycles left in this conversion
  logic                 phase_b;          // second half of a chopped pair
  logic [RESULT_W-1:0]  sample_a;         // first intermediate result
  logic [RESULT_W-1:0]  sample_b;         // last captured sample
  logic                 shut;             // shutdown latch
  logic [RESULT_W-1:0]  results [NCH];    // per-slot result store

  // decoded configuration of the current slot
  wire [2:0] cfg_pos  = i_ch_pos_sel[3*cur_ch +: 3];
  wire [2:0] cfg_neg  = i_ch_neg_sel[3*cur_ch +: 3];
  wire       cfg_chop = i_channel_chop_enable[cur_ch];
  // chopping swaps the pair for the second conversion
  wire [2:0] pos_next = (cfg_chop && phase_b) ? cfg_neg : cfg_pos;
  wire [2:0] neg_next = (cfg_chop && phase_b) ? cfg_pos : cfg_neg;

  // sign inversion when the positive side is common or ground against an input or a cal level
  wire pos_is_ref = cfg_pos == SEL_COMMON || cfg_pos == SEL_GROUND;
  wire neg_is_in  = cfg_neg <= SEL_IN4 || cfg_neg == SEL_CAL_HIGH || cfg_neg == SEL_CAL_LOW;
  wire invert     = pos_is_ref && neg_is_in;

  // chopped result: half the difference cancels the channel offset
  wire [RESULT_W:0]   diff    = {sample_a[RESULT_W-1], sample_a}
                              - {sample_b[RESULT_W-1], sample_b};
  wire [RESULT_W-1:0] raw     = cfg_chop ? diff[RESULT_W:1] : sample_b;
  wire [RESULT_W-1:0] final_v = invert ? (~raw + 24'h000001) : raw;

  // next slot and wrap decision
  wire [CH_W:0]    nxt      = next_on(i_ch_enable, cur_ch);
  wire             wrap     = nxt[CH_W];
  wire [CH_W-1:0]  start_ch = first_on(i_ch_enable);
  wire             one_ch   = mode == RM_ONE_CH_ONE || mode == RM_ONE_CH_CONT;
  wire             pass_end = one_ch || wrap;
  // one-read modes stop after their pass, continuous modes run on
  wire             stop_now = mode == RM_ONE_CH_ONE
                           || ((mode == RM_MULTI_ONE || mode == RM_MULTI_MULTI) && wrap);
  // multi one-read raises ready only once the whole pass is stored
  wire             ready_set = (state == ST_STORE)
                            && (mode != RM_MULTI_ONE || pass_end);

  // ----------------------------------------------------------------------------
  // conversion state machine
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state    <= ST_IDLE;
      mode     <= RM_ONE_CH_ONE;
      cur_ch   <= '0;
      cnt      <= '0;
      phase_b  <= 1'b0;
      sample_a <= '0;
      sample_b <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // no new work while shut down
          if (trigger && !shut && |i_ch_enable)
          begin
            mode    <= acc_read_mode_t'(i_read_mode);
            cur_ch  <= start_ch;
            cnt     <= PERIOD_W'(period);
            phase_b <= 1'b0;
            state   <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (i_stop || shut)
            state <= ST_IDLE;
          else if (cnt <= PERIOD_W'(1))
          begin
            if (cfg_chop && !phase_b)
            begin
              // first half done, run the swapped half at full period
              sample_a <= i_adc_sample;
              phase_b  <= 1'b1;
              cnt      <= PERIOD_W'(period);
            end
            else
            begin
              sample_b <= i_adc_sample;
              state    <= ST_STORE;
            end
          end
          else
            cnt <= cnt - PERIOD_W'(1);
        end
        ST_STORE:
        begin
          phase_b <= 1'b0;
          cnt     <= PERIOD_W'(period);
          if (stop_now || i_stop || shut)
            state <= ST_IDLE;
          else
          begin
            if (!one_ch)
              cur_ch <= nxt[CH_W-1:0];
            state <= ST_CONV;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // result store and ready flag; one store per slot even when chopped
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_result           <= '0;
      o_result_ch        <= 4'h0;
      o_result_ready_out <= 1'b0;
      for (int i = 0; i < NCH; i++)
        results[i] <= '0;
    end
    else
    begin
      if (state == ST_STORE)
      begin
        results[cur_ch] <= final_v;
        o_result        <= final_v;
        o_result_ch     <= 4'(cur_ch);
      end
      // a new result in the acknowledge cycle keeps the flag up
      if (ready_set)
        o_result_ready_out <= 1'b1;
      else if (i_result_ack)
        o_result_ready_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // burst readout of all enabled slots in one host transaction
  // ----------------------------------------------------------------------------
  logic [CH_W-1:0] b_ch;                  // slot on offer
  wire  [CH_W:0]   b_nxt   = next_on(i_ch_enable, b_ch);
  wire  [CH_W:0]   b_first = next_on(i_ch_enable, start_ch);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      b_ch          <= '0;
      o_burst_valid <= 1'b0;
      o_burst_word  <= '0;
      o_burst_ch    <= 4'h0;
      o_burst_last  <= 1'b0;
    end
    else if (!o_burst_valid)
    begin
      if (i_burst_cmd && |i_ch_enable)
      begin
        b_ch          <= start_ch;
        o_burst_valid <= 1'b1;
        o_burst_word  <= results[start_ch];
        o_burst_ch    <= 4'(start_ch);
        o_burst_last  <= b_first[CH_W];
      end
    end
    else if (i_burst_ready)
    begin
      if (o_burst_last)
        o_burst_valid <= 1'b0;
      else
      begin
        b_ch         <= b_nxt[CH_W-1:0];
        o_burst_word <= results[b_nxt[CH_W-1:0]];
        o_burst_ch   <= 4'(b_nxt[CH_W-1:0]);
        o_burst_last <= next_on(i_ch_enable, b_nxt[CH_W-1:0]) >> CH_W != '0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // temperature monitor; thresholds compare signed codes
  // ----------------------------------------------------------------------------
  wire signed [TEMP_W-1:0] t_now = signed'(i_temp_sample);
  wire t_shut = t_now >= signed'(TEMP_SHUT_CODE);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_temp_reading <= '0;
      o_temp_warning <= 1'b0;
      o_temp_alarm   <= 1'b0;
      shut           <= 1'b0;
    end
    else
    begin
      if (i_temp_valid)
      begin
        o_temp_reading <= i_temp_sample;
        o_temp_warning <= t_now >= signed'(TEMP_WARN_CODE);
        o_temp_alarm   <= t_now >= signed'(i_temp_alarm_thr);
      end
      // a crossing in the clear cycle wins over the clear
      if (i_temp_valid && t_shut)
        shut <= 1'b1;
      else if (i_shutdown_clear)
        shut <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // routing, filter and clock source outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_pos_sel             <= SEL_GROUND;
      o_neg_sel             <= SEL_GROUND;
      o_lv_sel              <= LV_AMP;
      o_converting          <= 1'b0;
      o_filter_single_cycle <= 1'b0;
      o_sinc_stages         <= 3'h1;
      o_line_reject         <= 1'b0;
      o_rate_sps            <= '0;
      o_interrupt_out_n     <= 1'b1;
      o_osc_enable          <= 1'b1;
      o_xtal_enable         <= 1'b0;
      o_ext_clk_sel         <= 1'b0;
    end
    else
    begin
      o_pos_sel             <= pos_next;
      o_neg_sel             <= neg_next;
      o_lv_sel              <= (i_lv_sel > LV_COARSE_REF) ? LV_AMP : i_lv_sel;
      o_converting          <= state != ST_IDLE;
      o_filter_single_cycle <= i_settle_single;
      o_sinc_stages         <= sinc_next;
      o_line_reject         <= sps <= LINE_REJECT_SPS;
      o_rate_sps            <= SPS_W'(sps);
      o_interrupt_out_n     <= !(o_temp_warning || o_temp_alarm || shut);
      o_osc_enable          <= i_clk_src == CLK_INTERNAL;
      o_xtal_enable         <= i_clk_src == CLK_CRYSTAL;
      o_ext_clk_sel         <= i_clk_src == CLK_EXTERNAL;
    end
  end

  assign o_temp_shutdown = shut;

endmodule : acc_conv_ctrl

/* verif/acc_conv_props.sv */
`timescale 1ns/1ps
module acc_conv_props
  import acc_pkg::*;
#(parameter int NCH = 8)(
  // watched ports
  input wire logic i_sys_clk, i_rst_n, i_start, i_result_ack, i_temp_valid, i_shutdown_clear,
  input wire logic [NCH-1:0] i_ch_enable, input wire logic [TEMP_W-1:0] i_temp_sample,
  input wire logic [1:0] i_clk_src, input wire logic [2:0] o_sinc_stages,
  input wire logic [SPS_W-1:0] o_rate_sps, input wire logic [RESULT_W-1:0] o_burst_word,
  input wire logic o_converting, o_result_ready_out, o_temp_warning, o_temp_shutdown,
  input wire logic o_interrupt_out_n, o_burst_valid, i_burst_ready, o_osc_enable,
  input wire logic o_xtal_enable, o_filter_single_cycle, o_line_reject
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_go; i_start && !o_converting && !o_temp_shutdown && |i_ch_enable; endsequence
  sequence s_hot(logic [15:0] c); i_temp_valid && $signed(i_temp_sample) >= $signed(c); endsequence
  property p_go; s_go |-> ##[1:2] o_converting; endproperty
  a_go: assert property (p_go) else $error("start not taken");
  property p_warn; s_hot(TEMP_WARN_CODE) |=> o_temp_warning; endproperty
  a_warn: assert property (p_warn) else $error("warning missing");
  property p_shut; s_hot(TEMP_SHUT_CODE) |=> o_temp_shutdown; endproperty
  a_shut: assert property (p_shut) else $error("shutdown missing");
  property p_latch; o_temp_shutdown && !i_shutdown_clear |=> o_temp_shutdown; endproperty
  a_latch: assert property (p_latch) else $error("shutdown dropped");
  property p_halt; o_temp_shutdown [*3] |-> !o_converting; endproperty
  a_halt: assert property (p_halt) else $error("converting while shut");
  property p_irq; o_temp_warning || o_temp_shutdown |=> !o_interrupt_out_n; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not low");
  property p_rdy; o_result_ready_out && !i_result_ack |=> o_result_ready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("ready dropped");
  property p_bst; o_burst_valid && !i_burst_ready |=> o_burst_valid && $stable(o_burst_word);
  endproperty
  a_bst: assert property (p_bst) else $error("burst word lost");
  property p_xtal; (i_clk_src == 2'h1) [*2] |-> o_xtal_enable && !o_osc_enable; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal not chosen");
  property p_sinc; o_filter_single_cycle == (o_sinc_stages == 3'h4); endproperty
  a_sinc: assert property (p_sinc) else $error("sinc cascade mismatch");
  // reset values are not a programmed rate, so skip the first edge after release
  property p_notch; $past(i_rst_n) |-> o_line_reject == (o_rate_sps <= 20'h3c); endproperty
  a_notch: assert property (p_notch) else $error("line reject mismatch");
endmodule : acc_conv_props
bind acc_conv_ctrl acc_conv_props #(.NCH(NCH)) i_acc_conv_props (.*);

/* verif/acc_host_model.sv */
`timescale 1ns/1ps
// host side: acknowledges results, takes burst words, slowly when stalling
module acc_host_model (
  input  wire logic i_sys_clk, i_rst_n, i_stall, i_ready, i_valid,
  output logic      o_ack, o_take
);
  // ack is a single pulse so a fresh store is never swallowed
  always_ff @(posedge i_sys_clk)
  begin
    o_ack  <= i_rst_n && i_ready && !o_ack;
    o_take <= i_rst_n && i_valid && (i_stall ? !o_take : 1'b1);
  end
endmodule : acc_host_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import acc_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, i_start = 0, i_stop = 0, i_trig_on_sync = 0, stall = 0;
  logic i_trig_on_frame_end = 0, i_settle_single = 0, i_burst_cmd = 0, i_sync = 0, i_sclk = 0;
  logic i_chip_select_n = 1, i_temp_valid = 0, i_shutdown_clear = 0, i_result_ack, i_burst_ready;
  logic [7:0] i_ch_enable = 8'h01, i_channel_chop_enable = 8'h00;
  logic [23:0] i_ch_pos_sel = 24'h0, i_ch_neg_sel = 24'h0, i_adc_sample = 24'h000120;
  logic [2:0] i_read_mode = 3'h0, i_rate_code = 3'h2, i_lv_sel = 3'h0;
  logic [1:0] i_clk_src = 2'h0;
  logic [15:0] i_temp_sample = 16'h0, i_temp_alarm_thr = 16'h1900;
  wire logic [23:0] o_result, o_burst_word;
  wire logic [2:0] o_pos_sel, o_neg_sel, o_lv_sel, o_sinc_stages;
  wire logic [3:0] o_result_ch, o_burst_ch;
  wire logic [19:0] o_rate_sps;
  wire logic [15:0] o_temp_reading;
  wire logic o_converting, o_filter_single_cycle, o_line_reject, o_result_ready_out, o_burst_valid;
  wire logic o_burst_last, o_temp_warning, o_temp_alarm, o_temp_shutdown, o_interrupt_out_n;
  wire logic o_osc_enable, o_xtal_enable, o_ext_clk_sel;
  int checks = 0, bad_count = 0;
  acc_conv_ctrl i_acc_conv_ctrl (.*);
  acc_host_model i_acc_host_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_stall(stall),
    .i_ready(o_result_ready_out), .i_valid(o_burst_valid), .o_ack(i_result_ack),
    .o_take(i_burst_ready));
  always #50 i_sys_clk = ~i_sys_clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #10;
  endtask : tick
  // one conversion on slot 0, latency window in cycles [lo, hi)
  task automatic conv(input logic [2:0] p, input logic [2:0] n, input logic c,
                      input logic [23:0] e, input int lo, input int hi);
    int k;
    i_ch_pos_sel[2:0] = p;
    i_ch_neg_sel[2:0] = n;
    i_channel_chop_enable[0] = c;
    tick(4);
    i_start = 1;
    tick(1);
    i_start = 0;
    for (k = 1; k < hi && o_result_ready_out !== 1'b1; k++) tick(1);
    chk("result", e, o_result);
    chk("latency", 24'h1, 24'(k >= lo && k < hi));
    tick(2);
    chk("route", {18'h0, p, n}, {18'h0, o_pos_sel, o_neg_sel});
  endtask : conv
  task automatic temp(input logic [15:0] t, input logic s);
    i_temp_sample = t;
    i_temp_valid = 1;
    tick(1);
    i_temp_valid = 0;
    tick(1);
    chk("reading", 24'(t), 24'(o_temp_reading));
    chk("warn", 24'($signed(t) >= $signed(TEMP_WARN_CODE)), 24'(o_temp_warning));
    chk("alarm", 24'($signed(t) >= $signed(i_temp_alarm_thr)), 24'(o_temp_alarm));
    chk("shut", 24'(s), 24'(o_temp_shutdown));
  endtask : temp
  task automatic burst;
    int n;
    i_ch_enable = 8'h05;
    stall = 1;
    i_burst_cmd = 1;
    tick(1);
    i_burst_cmd = 0;
    n = 0;
    repeat (20)
    begin
      if (o_burst_valid === 1'b1 && i_burst_ready === 1'b1)
      begin
        chk("burst ch", 24'(2 * n), 24'(o_burst_ch));
        chk("burst last", 24'(n), 24'(o_burst_last));
        chk("burst word", (n == 0) ? 24'hfffee0 : 24'h0, o_burst_word);
        n++;
      end
      tick(1);
    end
    chk("burst count", 24'h2, 24'(n));
    i_ch_enable = 8'h01;
  endtask : burst
  task automatic cfg;
    for (int v = 0; v < 7; v++)
    begin
      i_lv_sel = 3'(v);
      i_clk_src = 2'(v % 3);
      tick(3);
      chk("lv sel", (v > 5) ? 24'h0 : 24'(v), 24'(o_lv_sel));
      chk("clk", 24'(3'h1 << v % 3), 24'({o_ext_clk_sel, o_xtal_enable, o_osc_enable}));
    end
    i_settle_single = 1;
    tick(3);
    chk("single rate", 24'd36000, 24'(o_rate_sps));
    i_settle_single = 0;
    i_rate_code = 3'h6;
    tick(3);
    chk("notch", 24'h1, 24'(o_line_reject));
    i_rate_code = 3'h2;
    tick(3);
    chk("normal rate", 24'd144000, 24'(o_rate_sps));
  endtask : cfg
  // frame end after a falling serial clock starts a conversion, stop aborts it
  task automatic pins;
    i_trig_on_frame_end = 1;
    i_chip_select_n = 0;
    tick(4);
    i_sclk = 1;
    tick(4);
    i_sclk = 0;
    tick(4);
    i_chip_select_n = 1;
    tick(8);
    chk("frame start", 24'h1, 24'(o_converting));
    i_stop = 1;
    tick(1);
    i_stop = 0;
    tick(3);
    chk("stopped", 24'h0, 24'(o_converting));
  endtask : pins
  initial
  begin
    tick(16);
    i_rst_n = 1;
    cfg();
    conv(3'h0, 3'h0, 1'b0, 24'h000120, 65, 80);
    conv(3'h4, 3'h1, 1'b0, 24'hfffee0, 65, 80);
    pins();
    burst();
    conv(3'h7, 3'h5, 1'b1, 24'h000000, 134, 150);
    temp(TEMP_WARN_CODE - 16'h1, 1'b0);
    temp(TEMP_SHUT_CODE, 1'b1);
    i_start = 1;
    tick(1);
    i_start = 0;
    tick(3);
    chk("kept result", 24'h0, o_result);
    chk("refused", 24'h0, 24'(o_converting));
    chk("no ready", 24'h0, 24'(o_result_ready_out));
    i_shutdown_clear = 1;
    tick(1);
    i_shutdown_clear = 0;
    temp(16'h0640, 1'b0);
    end_sim();
  end
  initial
  begin
    repeat (3000) @(posedge i_sys_clk);
    bad_count++;
    end_sim();
  end
endmodule : testbench
